/* rtl/sra_dev.sv */
// Purpose: device end of the serial register access port
// Assumes: CLOCK is the master clock and much faster than the serial clock
// Notes: all link pins pass two flip-flops before use
`timescale 1ns/100ps
`default_nettype none
module sra_dev (
  input wire logic CLOCK,
  input wire logic RST_N,
  sra_link_if.dev LINK,
  input wire logic CONV_VALID,
  input wire logic [15:0] CONV_WORD,
  output logic [7:0] SETUP_REG,
  output logic [7:0] TEST_REG,
  output logic STANDBY,
  output logic DATA_UNREAD
);

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] din_s;
    logic sclk_d;
    sra_pkg::sra_dev_phase_t phase;
    logic [1:0] sel;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic dout;
    logic dout_oe;
    logic [7:0] cmd;
    logic [7:0] setup;
    logic [7:0] test;
    logic [15:0] data;
    logic data_ready_n;
    logic pend;
    logic [15:0] pend_word;
    logic [9:0] pulse;
  } sra_dev_st_t;

  sra_dev_st_t s;
  sra_dev_st_t n;

  // next state of the whole device end
  always_comb begin
    logic rise;
    logic fall;
    logic act;
    logic reading_data;
    logic [7:0] cbyte;
    logic [7:0] wbyte;
    logic [4:0] len;
    rise = 1'b0;
    fall = 1'b0;
    act = 1'b0;
    reading_data = 1'b0;
    cbyte = 8'h00;
    wbyte = 8'h00;
    len = sra_pkg::LEN_BYTE;
    n = s;
    // two-flop synchronisers; stage 0 feeds stage 1 only
    n.sclk_s = {s.sclk_s[0], LINK.sclk};
    n.cs_s = {s.cs_s[0], LINK.cs_n};
    n.din_s = {s.din_s[0], LINK.din};
    n.sclk_d = s.sclk_s[1];
    rise = s.sclk_s[1] & ~s.sclk_d;
    fall = ~s.sclk_s[1] & s.sclk_d;
    act = ~s.cs_s[1];
    cbyte = {s.sh[6:0], s.din_s[1]};
    wbyte = cbyte;
    len = (s.sel == sra_pkg::SEL_DATA) ? sra_pkg::LEN_WORD : sra_pkg::LEN_BYTE;
    if (act && rise) begin
      unique case (s.phase)
        sra_pkg::PH_CMD: begin
          n.sh = {s.sh[14:0], s.din_s[1]};
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == sra_pkg::LEN_BYTE - 5'h01) begin
            n.cnt = 5'h00;
            // a set top bit is no command: keep waiting, which resyncs the host
            if (!cbyte[sra_pkg::CMD_ZERO_BIT]) begin
              n.cmd = cbyte;
              n.sel = cbyte[sra_pkg::CMD_SEL_HI:sra_pkg::CMD_SEL_LO];
              if (cbyte[sra_pkg::CMD_RW_BIT]) begin
                n.phase = sra_pkg::PH_RD;
                unique case (n.sel)
                  sra_pkg::SEL_CMD: n.sh = {cbyte, 8'h00};
                  sra_pkg::SEL_SETUP: n.sh = {s.setup, 8'h00};
                  sra_pkg::SEL_TEST: n.sh = {s.test, 8'h00};
                  sra_pkg::SEL_DATA: n.sh = s.data;
                endcase
              end else begin
                n.phase = sra_pkg::PH_WR;
              end
            end
          end
        end
        sra_pkg::PH_WR: begin
          n.sh = {s.sh[14:0], s.din_s[1]};
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == len - 5'h01) begin
            n.phase = sra_pkg::PH_CMD;
            n.cnt = 5'h00;
            unique case (s.sel)
              sra_pkg::SEL_SETUP: n.setup = wbyte;
              sra_pkg::SEL_TEST: n.test = wbyte;
              sra_pkg::SEL_CMD, sra_pkg::SEL_DATA: ;
            endcase
          end
        end
        sra_pkg::PH_RD: begin
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == len - 5'h01) begin
            n.phase = sra_pkg::PH_CMD;
            n.cnt = 5'h00;
            if (s.sel == sra_pkg::SEL_DATA) begin
              n.data_ready_n = 1'b1;
            end
          end
        end
      endcase
    end
    if (act && fall && s.phase == sra_pkg::PH_RD) begin
      n.dout = s.sh[15];
      n.sh = {s.sh[14:0], 1'b0};
    end
    n.dout_oe = act && (n.phase == sra_pkg::PH_RD);
    // a new word arriving while the last waits replaces it; set wins
    if (CONV_VALID) begin
      n.pend = 1'b1;
      n.pend_word = CONV_WORD;
    end
    // the result never changes under a data read in flight
    reading_data = (s.phase == sra_pkg::PH_RD) && (s.sel == sra_pkg::SEL_DATA);
    if (s.pend && !reading_data) begin
      if (s.pulse != 10'h000) begin
        n.pulse = s.pulse - 10'h001;
        if (s.pulse == 10'h001) begin
          n.data = s.pend_word;
          n.data_ready_n = 1'b0;
          n.pend = CONV_VALID;
        end
      end else if (!s.data_ready_n) begin
        n.data_ready_n = 1'b1;
        n.pulse = sra_pkg::READY_PULSE_CYC;
      end else begin
        n.data = s.pend_word;
        n.data_ready_n = 1'b0;
        n.pend = CONV_VALID;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.sclk_s <= 2'h3;
      s.cs_s <= 2'h3;
      s.din_s <= 2'h3;
      s.sclk_d <= 1'b1;
      s.phase <= sra_pkg::PH_CMD;
      s.cmd <= sra_pkg::CMD_RST;
      s.setup <= sra_pkg::SETUP_RST;
      s.test <= sra_pkg::TEST_RST;
      s.data <= sra_pkg::DATA_RST;
      s.data_ready_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign LINK.dout = s.dout;
  assign LINK.dout_oe = s.dout_oe;
  assign LINK.data_ready_n = s.data_ready_n;
  assign SETUP_REG = s.setup;
  assign TEST_REG = s.test;
  assign STANDBY = s.cmd[sra_pkg::CMD_STBY_BIT];
  assign DATA_UNREAD = ~s.data_ready_n;

endmodule : sra_dev
`default_nettype wire

/* rtl/sra_host.sv */
// Purpose: host end; runs one command write plus one data access per request
// Assumes: HALF of at least 6 so synchroniser delay fits inside half a bit
// Notes: serial clock derived by division, idles high, chip select low per frame
`timescale 1ns/100ps
`default_nettype none
module sra_host #(
  parameter int HALF = sra_pkg::SCLK_HALF_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  sra_link_if.host LINK,
  input wire logic START,
  input wire logic RD,
  input wire logic [1:0] SEL,
  input wire logic STBY,
  input wire logic [15:0] WDATA,
  output logic BUSY,
  output logic DONE,
  output logic [15:0] RDATA,
  output logic DATA_READY
);

  typedef struct packed {
    logic [1:0] dout_s;
    logic [1:0] ready_s;
    sra_pkg::sra_host_phase_t phase;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic din;
    logic [23:0] sh;
    logic [4:0] nbits;
    logic [4:0] bits;
    logic len16;
    logic [15:0] rsh;
    logic [15:0] rdata;
    logic done;
  } sra_host_st_t;

  sra_host_st_t s;
  sra_host_st_t n;

  // next state of the host end
  always_comb begin
    logic tick;
    logic [7:0] cbyte;
    tick = 1'b0;
    cbyte = 8'h00;
    n = s;
    n.dout_s = {s.dout_s[0], LINK.dout_line};
    n.ready_s = {s.ready_s[0], LINK.data_ready_n};
    n.done = 1'b0;
    tick = (s.div == 8'(HALF - 1));
    n.div = (s.phase == sra_pkg::HS_IDLE || tick) ? 8'h00 : s.div + 8'h01;
    cbyte = 8'h00;
    cbyte[sra_pkg::CMD_SEL_HI:sra_pkg::CMD_SEL_LO] = SEL;
    cbyte[sra_pkg::CMD_RW_BIT] = RD;
    cbyte[sra_pkg::CMD_STBY_BIT] = STBY;
    unique case (s.phase)
      sra_pkg::HS_IDLE: begin
        if (START) begin
          n.phase = sra_pkg::HS_RUN;
          n.cs_n = 1'b0;
          n.len16 = (SEL == sra_pkg::SEL_DATA);
          n.nbits = n.len16 ? sra_pkg::LEN_BYTE + sra_pkg::LEN_WORD
                            : sra_pkg::LEN_BYTE + sra_pkg::LEN_BYTE;
          n.bits = 5'h00;
          n.sh = RD ? {cbyte, 16'hFFFF}
                    : (n.len16 ? {cbyte, WDATA} : {cbyte, WDATA[7:0], 8'hFF});
        end
      end
      sra_pkg::HS_RUN: begin
        if (tick) begin
          n.sclk = ~s.sclk;
          if (s.sclk) begin
            n.din = s.sh[23];
            n.sh = {s.sh[22:0], 1'b1};
          end else begin
            n.rsh = {s.rsh[14:0], s.dout_s[1]};
            n.bits = s.bits + 5'h01;
            if (s.bits == s.nbits - 5'h01) begin
              n.phase = sra_pkg::HS_END;
            end
          end
        end
      end
      sra_pkg::HS_END: begin
        // one half period of hold before chip select rises
        if (tick) begin
          n.phase = sra_pkg::HS_IDLE;
          n.cs_n = 1'b1;
          n.din = 1'b1;
          n.done = 1'b1;
          n.rdata = s.len16 ? s.rsh : {8'h00, s.rsh[7:0]};
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.dout_s <= 2'h3;
      s.ready_s <= 2'h3;
      s.phase <= sra_pkg::HS_IDLE;
      s.sclk <= 1'b1;
      s.cs_n <= 1'b1;
      s.din <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign LINK.sclk = s.sclk;
  assign LINK.cs_n = s.cs_n;
  assign LINK.din = s.din;
  assign BUSY = (s.phase != sra_pkg::HS_IDLE);
  assign DONE = s.done;
  assign RDATA = s.rdata;
  assign DATA_READY = ~s.ready_s[1];

endmodule : sra_host
`default_nettype wire

/* rtl/sra_link_if.sv */
// Purpose: serial link between the host end and the device end
// Assumes: serial clock idles high, driven by the host
// Notes: data out is three-state; the line idles high when not driven
`timescale 1ns/100ps
`default_nettype none
interface sra_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic data_ready_n;
  wire dout_line;

  // resolve the three-state data out with a weak idle high
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (input sclk, input cs_n, input din, output dout, output dout_oe,
    output data_ready_n);
  modport host (output sclk, output cs_n, output din, input dout_line, input data_ready_n);
endinterface : sra_link_if
`default_nettype wire

/* rtl/sra_pkg.sv */
// Purpose: shared constants and types of the serial register access port
// Assumes: device master clock is the module clock CLOCK
// Notes: command byte layout and register select codes are fixed here
package sra_pkg;
  // command byte fields
  localparam int CMD_ZERO_BIT = 7;
  localparam int CMD_SEL_HI = 5;
  localparam int CMD_SEL_LO = 4;
  localparam int CMD_RW_BIT = 3;
  localparam int CMD_STBY_BIT = 2;
  // register select codes
  localparam logic [1:0] SEL_CMD = 2'h0;
  localparam logic [1:0] SEL_SETUP = 2'h1;
  localparam logic [1:0] SEL_TEST = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  // transfer lengths in serial clocks
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
  // values after reset
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // ready pulse of an overwritten word, in master clock periods
  localparam int READY_PULSE_CLKS = 500;
  localparam logic [9:0] READY_PULSE_CYC = 10'(READY_PULSE_CLKS);
  // host serial clock half period in module clocks
  localparam int SCLK_HALF_CYC = 8;
  typedef enum logic [1:0] {PH_CMD, PH_WR, PH_RD} sra_dev_phase_t;
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_END} sra_host_phase_t;
endpackage : sra_pkg

/* sim/sra_chk.sv */
// Purpose: link checker of the serial register port
// Assumes: both ends share one link, default host divider
// Notes: watches the link wires only
`timescale 1ns/100ps
`default_nettype none
module sra_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic data_ready_n
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic ow_q;
  logic [9:0] cnt_q;
  // time a ready pulse begun outside a frame; a read-driven rise is under select
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ow_q <= 1'b0;
      cnt_q <= 10'h000;
    end else if ($rose(data_ready_n) && cs_n) begin
      ow_q <= 1'b1;
      cnt_q <= 10'h001;
    end else if (!data_ready_n) begin
      ow_q <= 1'b0;
    end else if (ow_q) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  sequence s_idle;
    cs_n && sclk && din && data_ready_n && !dout_oe;
  endsequence
  property p_rst;
    $rose(RST_N) |-> s_idle;
  endproperty
  property p_wait;
    $rose(RST_N) |-> !dout_oe [*8];
  endproperty
  property p_desel;
    cs_n |-> !dout_oe;
  endproperty
  property p_oe_rise;
    $rose(dout_oe) |-> !cs_n && sclk;
  endproperty
  property p_shift;
    dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
  endproperty
  property p_sample;
    $rose(sclk) |-> $stable(din);
  endproperty
  property p_idle;
    cs_n |-> sclk;
  endproperty
  property p_pulse;
    ow_q |-> (data_ready_n && cnt_q < sra_pkg::READY_PULSE_CYC)
      || (!data_ready_n && cnt_q == sra_pkg::READY_PULSE_CYC);
  endproperty
  a_rst: assert property (p_rst) else $error("link not idle after reset");
  a_wait: assert property (p_wait) else $error("output before command");
  a_desel: assert property (p_desel) else $error("output while deselected");
  a_oe_rise: assert property (p_oe_rise) else $error("output enable misplaced");
  a_shift: assert property (p_shift) else $error("data out moved on high clock");
  a_sample: assert property (p_sample) else $error("data in moved at sample");
  a_idle: assert property (p_idle) else $error("serial clock not idle high");
  a_pulse: assert property (p_pulse) else $error("ready pulse length wrong");
endmodule : sra_chk
`default_nettype wire

/* sim/test_serial_register_access_port.sv */
// Purpose: bench of host and device ends of the serial register port
// Assumes: default host divider, so each transfer takes a few hundred cycles
// Notes: each scenario but t_reset drives host requests and judges the result
`timescale 1ns/100ps
`default_nettype none
module test_serial_register_access_port;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic [1:0] sel = 2'h0;
  logic stby = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic conv_valid = 1'b0;
  logic [15:0] conv_word = 16'h0000;
  logic busy, done, data_ready, standby, data_unread;
  logic [15:0] rdata;
  logic [7:0] setup_reg, test_reg;
  int err_count = 0;
  int check_count = 0;
  sra_link_if link ();
  sra_host i_sra_host (.CLOCK(clock), .RST_N(rst_n), .LINK(link.host), .START(start),
    .RD(rd), .SEL(sel), .STBY(stby), .WDATA(wdata), .BUSY(busy), .DONE(done),
    .RDATA(rdata), .DATA_READY(data_ready));
  sra_dev i_sra_dev (.CLOCK(clock), .RST_N(rst_n), .LINK(link.dev), .CONV_VALID(conv_valid),
    .CONV_WORD(conv_word), .SETUP_REG(setup_reg), .TEST_REG(test_reg), .STANDBY(standby),
    .DATA_UNREAD(data_unread));
  sra_chk i_sra_chk (.CLOCK(clock), .RST_N(rst_n), .sclk(link.sclk), .cs_n(link.cs_n),
    .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
    .data_ready_n(link.data_ready_n));
  // 25 MHz clock
  always #20 clock = ~clock;
  task automatic conclude;
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // one command write plus data access; bounded wait on the done pulse
  task automatic xfer(input logic r, input logic [1:0] s, input logic b, input logic [15:0] w);
    int n;
    n = 0;
    tick(1);
    rd = r;
    sel = s;
    stby = b;
    wdata = w;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    check("busy", 16'(busy), 16'h0001);
    while (done !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    // a transfer that never ends is caught here
    check("done", 16'(done), 16'h0001);
    check("busy end", 16'(busy), 16'h0000);
  endtask : xfer
  task automatic conv(input logic [15:0] w);
    conv_word = w;
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
  endtask : conv
  task automatic wait_ready;
    int n;
    n = 0;
    while (data_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("data ready", 16'(data_ready), 16'h0001);
  endtask : wait_ready
  task automatic t_reset;
    check("data_ready_n", 16'(link.data_ready_n), 16'h0001);
    check("setup", 16'(setup_reg), 16'(sra_pkg::SETUP_RST));
    check("standby", 16'(standby), 16'h0000);
  endtask : t_reset
  task automatic t_write;
    xfer(1'b0, sra_pkg::SEL_SETUP, 1'b0, 16'h00A5);
    check("setup", 16'(setup_reg), 16'h00A5);
    xfer(1'b0, sra_pkg::SEL_TEST, 1'b1, 16'h003C);
    check("test", 16'(test_reg), 16'h003C);
    check("standby", 16'(standby), 16'h0001);
    check("setup kept", 16'(setup_reg), 16'h00A5);
  endtask : t_write
  task automatic t_read;
    xfer(1'b1, sra_pkg::SEL_SETUP, 1'b0, 16'hFFFF);
    check("rd setup", rdata, 16'h00A5);
    check("standby", 16'(standby), 16'h0000);
    xfer(1'b1, sra_pkg::SEL_TEST, 1'b0, 16'hFFFF);
    check("rd test", rdata, 16'h003C);
    xfer(1'b1, sra_pkg::SEL_CMD, 1'b0, 16'hFFFF);
    check("rd cmd", rdata, 16'(8'h01 << sra_pkg::CMD_RW_BIT));
    check("test kept", 16'(test_reg), 16'h003C);
  endtask : t_read
  // a write aimed at the result register, then a new word that reads back whole and clears ready
  task automatic t_conv;
    xfer(1'b0, sra_pkg::SEL_DATA, 1'b0, 16'h0F0F);
    conv(16'hBEEF);
    wait_ready();
    check("unread", 16'(data_unread), 16'h0001);
    xfer(1'b1, sra_pkg::SEL_DATA, 1'b0, 16'hFFFF);
    check("rd data", rdata, 16'hBEEF);
    check("data_ready_n", 16'(link.data_ready_n), 16'h0001);
  endtask : t_conv
  // unread word overwritten: ready goes high for the pulse, then low again
  task automatic t_over;
    conv(16'h1234);
    wait_ready();
    conv(16'h5678);
    // ready rises one cycle after the word is taken and stays up for the full pulse
    tick(1);
    check("pulse hi", 16'(link.data_ready_n), 16'h0001);
    tick(sra_pkg::READY_PULSE_CLKS - 1);
    check("pulse end", 16'(link.data_ready_n), 16'h0001);
    tick(1);
    check("reload", 16'(link.data_ready_n), 16'h0000);
    xfer(1'b1, sra_pkg::SEL_DATA, 1'b0, 16'hFFFF);
    check("rd new", rdata, 16'h5678);
  endtask : t_over
  // reset in mid-run with a word unread: ready high, registers back to defaults
  task automatic t_rst_mid;
    conv(16'hA5A5);
    wait_ready();
    rst_n = 1'b0;
    tick(2);
    check("data_ready_n", 16'(link.data_ready_n), 16'h0001);
    check("setup", 16'(setup_reg), 16'(sra_pkg::SETUP_RST));
    check("test", 16'(test_reg), 16'(sra_pkg::TEST_RST));
    check("host ready", 16'(data_ready), 16'h0000);
    tick(18);
    rst_n = 1'b1;
    tick(5);
    xfer(1'b1, sra_pkg::SEL_DATA, 1'b0, 16'hFFFF);
    check("rd data rst", rdata, sra_pkg::DATA_RST);
  endtask : t_rst_mid
  initial begin
    tick(2);
    t_reset();
    tick(18);
    rst_n = 1'b1;
    tick(5);
    t_write();
    t_read();
    t_conv();
    t_over();
    t_rst_mid();
    conclude();
  end
  // watchdog well beyond the expected run of some 3500 cycles
  initial begin
    tick(20000);
    err_count++;
    conclude();
  end
endmodule : test_serial_register_access_port
`default_nettype wire
